/* File: pll_regs.svh */
`ifndef PLL_REGS_SVH
`define PLL_REGS_SVH

// Division word and its fields
`define PLL_WORD_W        17
`define PLL_A_W           7
`define PLL_N_W           10
`define PLL_A_LSB         0
`define PLL_N_LSB         7
`define PLL_A_BIT7_IDX    6
`define PLL_N_MIN         10'h005
`define PLL_LATCH_RST     17'h00280

// Reference divider: log2 of the ratio for select codes 0..7
`define PLL_REF_SEL_W     3
`define PLL_REF_CNT_W     11
`define PLL_REF_LOG0      4'h3
`define PLL_REF_LOG1      4'h4
`define PLL_REF_LOG2      4'h6
`define PLL_REF_LOG3      4'h7
`define PLL_REF_LOG4      4'h8
`define PLL_REF_LOG5      4'h9
`define PLL_REF_LOG6      4'ha
`define PLL_REF_LOG7      4'hb

// Controller register map (byte addresses)
`define PLL_WORD_OFF      4'h0
`define PLL_CTRL_OFF      4'h4
`define PLL_STAT_OFF      4'h8
`define PLL_CTRL_GO_BIT   0
`define PLL_CTRL_PSEL_BIT 1
`define PLL_CTRL_SEL_LSB  2
`define PLL_STAT_BUSY_BIT 0
`define PLL_STAT_REF_BIT  1
`define PLL_WORD_RST      17'h00280
`define PLL_CTRL_RST      5'h00

// Link timing in controller clock cycles
`define PLL_SCLK_HALF     16
`define PLL_LOAD_CYCLES   64

`endif

/* File: pll_pkg.sv */
`default_nettype none
package pll_pkg;
  `include "pll_regs.svh"

  typedef logic [`PLL_WORD_W-1:0]    word_t;
  typedef logic [`PLL_A_W-1:0]       swallow_t;
  typedef logic [`PLL_N_W-1:0]       prog_t;
  typedef logic [`PLL_REF_SEL_W-1:0] ref_sel_t;

  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_SHIFT,
    ST_LOAD
  } host_state_t;
endpackage
`default_nettype wire

/* File: pll_link_if.sv */
`default_nettype none
interface pll_link_if;
  import pll_pkg::*;
  // Serial word transfer
  logic     serial_clk;
  logic     serial_data;
  logic     load_strobe;
  // Static reference ratio select
  ref_sel_t ref_ratio_sel;

  modport host
  (
    output serial_clk,
    output serial_data,
    output load_strobe,
    output ref_ratio_sel
  );

  modport device
  (
    input serial_clk,
    input serial_data,
    input load_strobe,
    input ref_ratio_sel
  );
endinterface
`default_nettype wire

/* File: pll_sync2.sv */
`default_nettype none
module pll_sync2 #(
  parameter int WIDTH = 1
)
(
  // Destination clock
  input  wire logic             clk,
  // Foreign level and its synchronised copy
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  // Two stages; the first feeds only the second
  always_ff @(posedge clk)
  begin
    meta_r <= d;
    q      <= meta_r;
  end
endmodule // pll_sync2
`default_nettype wire

/* File: pll_divider_device.sv */
`default_nettype none
`include "pll_regs.svh"
module pll_divider_device
  import pll_pkg::*;
#(
  parameter int WORD_W = `PLL_WORD_W,
  parameter int A_W    = `PLL_A_W,
  parameter int N_W    = `PLL_N_W
)
(
  // Oscillator clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Serial link from the controller
  pll_link_if.device link,
  // Prescaler output into the divider
  input  wire logic fin_clk,
  // Prescaler modulus control
  output logic      modulus_ctl,
  // Divider outputs toward the phase detector
  output logic      reference_pulse,
  output logic      compare_pulse
);

  // Serial clock domain

  word_t shift_r;
  word_t shift_nxt;

  always_comb
  begin
    shift_nxt = {shift_r[WORD_W-2:0], link.serial_data};
  end

  // No reset: the serial clock only runs inside frames
  always_ff @(posedge link.serial_clk)
  begin
    shift_r <= shift_nxt;
  end

  // Divider input domain, clocked on the falling edge of fin

  logic fin_fall_clk;
  logic fin_rst_n;
  logic load_sync;

  // Modulus control must move with the fin fall, so this domain runs inverted
  assign fin_fall_clk = ~fin_clk;

  pll_sync2 #(
    .WIDTH (1)
  ) u_fin_rst_sync (
    .clk (fin_fall_clk),
    .d   (aresetn),
    .q   (fin_rst_n)
  );

  pll_sync2 #(
    .WIDTH (1)
  ) u_load_sync (
    .clk (fin_fall_clk),
    .d   (link.load_strobe),
    .q   (load_sync)
  );

  word_t    latch_r;
  word_t    latch_nxt;
  prog_t    n_cnt_r;
  prog_t    n_cnt_nxt;
  swallow_t a_cnt_r;
  swallow_t a_cnt_nxt;
  logic     mod_r;
  logic     mod_nxt;
  logic     cmp_r;
  logic     cmp_nxt;
  swallow_t preset_a;
  prog_t    preset_n;

  // Shift contents are stable while the strobe is high, since the host
  // stops the serial clock before raising it
  always_comb
  begin
    if (load_sync)
    begin
      latch_nxt = shift_r;
    end
    else
    begin
      latch_nxt = latch_r;
    end
  end

  always_ff @(posedge fin_fall_clk)
  begin
    if (!fin_rst_n)
    begin
      latch_r <= `PLL_LATCH_RST;
    end
    else
    begin
      latch_r <= latch_nxt;
    end
  end

  assign preset_a = latch_r[`PLL_A_LSB +: A_W];
  assign preset_n = latch_r[`PLL_N_LSB +: N_W];

  // A full output cycle is N prescaler periods; the first A of them use
  // base plus one, giving N*M + A input cycles per compare pulse
  always_comb
  begin
    cmp_nxt = 1'b0;
    if (n_cnt_r <= 10'h001)
    begin
      n_cnt_nxt = preset_n;
      a_cnt_nxt = preset_a;
      cmp_nxt   = 1'b1;
    end
    else
    begin
      n_cnt_nxt = n_cnt_r - 10'h001;
      if (a_cnt_r != 7'h00)
      begin
        a_cnt_nxt = a_cnt_r - 7'h01;
      end
      else
      begin
        a_cnt_nxt = a_cnt_r;
      end
    end
    mod_nxt = (a_cnt_nxt == 7'h00);
  end

  always_ff @(posedge fin_fall_clk)
  begin
    if (!fin_rst_n)
    begin
      n_cnt_r <= `PLL_N_MIN;
      a_cnt_r <= 7'h00;
      mod_r   <= 1'b1;
      cmp_r   <= 1'b0;
    end
    else
    begin
      n_cnt_r <= n_cnt_nxt;
      a_cnt_r <= a_cnt_nxt;
      mod_r   <= mod_nxt;
      cmp_r   <= cmp_nxt;
    end
  end

  assign modulus_ctl   = mod_r;
  assign compare_pulse = cmp_r;

  // Oscillator domain: reference divider

  ref_sel_t sel_sync;
  logic [3:0] ref_log;
  logic [`PLL_REF_CNT_W-1:0] ref_last;
  logic [`PLL_REF_CNT_W-1:0] ref_cnt_r;
  logic [`PLL_REF_CNT_W-1:0] ref_cnt_nxt;
  logic ref_r;
  logic ref_nxt;

  // Select pins are static but still come from outside this clock
  pll_sync2 #(
    .WIDTH (`PLL_REF_SEL_W)
  ) u_sel_sync (
    .clk (aclk),
    .d   (link.ref_ratio_sel),
    .q   (sel_sync)
  );

  always_comb
  begin
    case (sel_sync)
      3'h0:    ref_log = `PLL_REF_LOG0;
      3'h1:    ref_log = `PLL_REF_LOG1;
      3'h2:    ref_log = `PLL_REF_LOG2;
      3'h3:    ref_log = `PLL_REF_LOG3;
      3'h4:    ref_log = `PLL_REF_LOG4;
      3'h5:    ref_log = `PLL_REF_LOG5;
      3'h6:    ref_log = `PLL_REF_LOG6;
      3'h7:    ref_log = `PLL_REF_LOG7;
      default: ref_log = `PLL_REF_LOG0;
    endcase
  end

  // Ratio minus one is all ones below the ratio bit
  assign ref_last = ~(11'h7ff << ref_log);

  // A select change mid-cycle cuts the count short instead of overrunning
  always_comb
  begin
    if (ref_cnt_r >= ref_last)
    begin
      ref_cnt_nxt = 11'h000;
      ref_nxt     = 1'b1;
    end
    else
    begin
      ref_cnt_nxt = ref_cnt_r + 11'h001;
      ref_nxt     = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ref_cnt_r <= 11'h000;
      ref_r     <= 1'b0;
    end
    else
    begin
      ref_cnt_r <= ref_cnt_nxt;
      ref_r     <= ref_nxt;
    end
  end

  assign reference_pulse = ref_r;

endmodule // pll_divider_device
`default_nettype wire

/* File: pll_serial_host.sv */
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`default_nettype none
`include "pll_regs.svh"
module pll_serial_host
  import pll_pkg::*;
#(
  parameter int SCLK_HALF   = `PLL_SCLK_HALF,
  parameter int LOAD_CYCLES = `PLL_LOAD_CYCLES
)
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [3:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // AXI4-Lite write response
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  // AXI4-Lite read
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [3:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // Prescaler modulus pair select
  output logic             prescaler_ratio_select,
  // Serial link to the synthesizer
  pll_link_if.host         link
);

  // Bus slave
  logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bvalid_nxt, rvalid_nxt;
  logic [3:0]  awaddr_r, awaddr_nxt, waddr;
  logic [31:0] wdata_r, wdata_nxt, wd, rdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt, ws;
  logic [1:0]  bresp_nxt, rresp_nxt;
  logic        wr_do;

  assign awready = !aw_got_r && !bvalid;
  assign wready  = !w_got_r && !bvalid;
  assign arready = !rvalid;
  assign waddr   = aw_got_r ? awaddr_r : awaddr;
  assign wd      = w_got_r ? wdata_r : wdata;
  assign ws      = w_got_r ? wstrb_r : wstrb;
  assign wr_do   = (aw_got_r || (awvalid && awready)) && (w_got_r || (wvalid && wready));

  // Controller state
  word_t       word_r, word_nxt, sh_r, sh_nxt;
  logic [4:0]  ctrl_r, ctrl_nxt;
  logic        refused_r, refused_nxt, go, psel_now;
  host_state_t st_r, st_nxt;
  logic [7:0]  div_r, div_nxt;
  logic [4:0]  bit_r, bit_nxt;
  logic        sclk_r, sclk_nxt, strobe_r, strobe_nxt;
  word_t       send_word;

  assign go = wr_do && waddr == `PLL_CTRL_OFF && ws[0] && wd[`PLL_CTRL_GO_BIT] && st_r == ST_IDLE;

  // In 64/65 mode the swallow value must stay below 64; a GO write that
  // switches the pair in the same beat must already send the cleared bit
  always_comb
  begin
    send_word = word_r;
    psel_now  = ctrl_r[`PLL_CTRL_PSEL_BIT];
    if (wr_do && waddr == `PLL_CTRL_OFF && ws[0])
    begin
      psel_now = wd[`PLL_CTRL_PSEL_BIT];
    end
    if (psel_now)
    begin
      send_word[`PLL_A_BIT7_IDX] = 1'b0;
    end
  end

  always_comb
  begin
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt  = wdata_r;
    wstrb_nxt  = wstrb_r;
    bvalid_nxt = bvalid && !bready;
    bresp_nxt  = bresp;
    rvalid_nxt = rvalid && !rready;
    rdata_nxt  = rdata;
    rresp_nxt  = rresp;
    word_nxt   = word_r;
    ctrl_nxt   = ctrl_r;
    refused_nxt = refused_r;
    if (awvalid && awready)
    begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = awaddr;
    end
    if (wvalid && wready)
    begin
      w_got_nxt = 1'b1;
      wdata_nxt = wdata;
      wstrb_nxt = wstrb;
    end
    if (wr_do)
    begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = 2'h0;
      case (waddr)
        `PLL_WORD_OFF:
        begin
          if (ws[0]) word_nxt[7:0]   = wd[7:0];
          if (ws[1]) word_nxt[15:8]  = wd[15:8];
          if (ws[2]) word_nxt[16]    = wd[16];
        end
        `PLL_CTRL_OFF:
        begin
          if (ws[0]) ctrl_nxt = {wd[4:1], 1'b0};
        end
        `PLL_STAT_OFF:
        begin
          if (ws[0] && wd[`PLL_STAT_REF_BIT]) refused_nxt = 1'b0;
        end
        default: bresp_nxt = 2'h2;
      endcase
    end
    // Refusal set wins over a clear in the same cycle
    if (go && send_word[`PLL_N_LSB +: `PLL_N_W] < `PLL_N_MIN)
    begin
      refused_nxt = 1'b1;
    end
    if (arvalid && arready)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = 2'h0;
      case (araddr)
        `PLL_WORD_OFF: rdata_nxt = {15'h0000, word_r};
        `PLL_CTRL_OFF: rdata_nxt = {27'h0000000, ctrl_r};
        `PLL_STAT_OFF: rdata_nxt = {30'h00000000, refused_r, st_r != ST_IDLE};
        default:
        begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = 2'h2;
        end
      endcase
    end
  end

  // Link sequencer: data moves on the falling serial edge, the device
  // samples on the rising one
  always_comb
  begin
    st_nxt     = st_r;
    div_nxt    = div_r;
    bit_nxt    = bit_r;
    sclk_nxt   = sclk_r;
    strobe_nxt = strobe_r;
    sh_nxt     = sh_r;
    case (st_r)
      ST_IDLE:
      begin
        if (go && send_word[`PLL_N_LSB +: `PLL_N_W] >= `PLL_N_MIN)
        begin
          sh_nxt  = send_word;
          div_nxt = 8'h00;
          bit_nxt = 5'h00;
          st_nxt  = ST_SHIFT;
        end
      end
      ST_SHIFT:
      begin
        div_nxt = div_r + 8'h01;
        if (div_r == 8'(SCLK_HALF - 1))
        begin
          div_nxt  = 8'h00;
          sclk_nxt = !sclk_r;
          if (sclk_r)
          begin
            sh_nxt  = {sh_r[`PLL_WORD_W-2:0], 1'b0};
            bit_nxt = bit_r + 5'h01;
            if (bit_r == 5'(`PLL_WORD_W - 1))
            begin
              strobe_nxt = 1'b1;
              st_nxt     = ST_LOAD;
            end
          end
        end
      end
      ST_LOAD:
      begin
        div_nxt = div_r + 8'h01;
        if (div_r == 8'(LOAD_CYCLES - 1))
        begin
          strobe_nxt = 1'b0;
          st_nxt     = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      awaddr_r  <= 4'h0;
      wdata_r   <= 32'h00000000;
      wstrb_r   <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= 2'h0;
      rvalid    <= 1'b0;
      rdata     <= 32'h00000000;
      rresp     <= 2'h0;
      word_r    <= `PLL_WORD_RST;
      ctrl_r    <= `PLL_CTRL_RST;
      refused_r <= 1'b0;
      st_r      <= ST_IDLE;
      div_r     <= 8'h00;
      bit_r     <= 5'h00;
      sclk_r    <= 1'b0;
      strobe_r  <= 1'b0;
      sh_r      <= `PLL_WORD_RST;
    end
    else
    begin
      aw_got_r  <= aw_got_nxt;
      w_got_r   <= w_got_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bvalid    <= bvalid_nxt;
      bresp     <= bresp_nxt;
      rvalid    <= rvalid_nxt;
      rdata     <= rdata_nxt;
      rresp     <= rresp_nxt;
      word_r    <= word_nxt;
      ctrl_r    <= ctrl_nxt;
      refused_r <= refused_nxt;
      st_r      <= st_nxt;
      div_r     <= div_nxt;
      bit_r     <= bit_nxt;
      sclk_r    <= sclk_nxt;
      strobe_r  <= strobe_nxt;
      sh_r      <= sh_nxt;
    end
  end

  assign link.serial_clk        = sclk_r;
  assign link.serial_data       = sh_r[`PLL_WORD_W-1];
  assign link.load_strobe       = strobe_r;
  assign link.ref_ratio_sel     = ctrl_r[`PLL_CTRL_SEL_LSB +: `PLL_REF_SEL_W];
  assign prescaler_ratio_select = ctrl_r[`PLL_CTRL_PSEL_BIT];

endmodule // pll_serial_host
`default_nettype wire

/* File: pll_link_properties.sv */
`default_nettype none
`include "pll_regs.svh"
module pll_link_properties
  import pll_pkg::*;
#(
  parameter int SCLK_HALF   = `PLL_SCLK_HALF,
  parameter int LOAD_CYCLES = `PLL_LOAD_CYCLES
)
(
  // Controller clock and reset
  input wire logic     aclk,
  input wire logic     aresetn,
  // Link signals
  input wire logic     serial_clk,
  input wire logic     serial_data,
  input wire logic     load_strobe,
  input wire ref_sel_t ref_ratio_sel
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam int HALF_M1 = SCLK_HALF - 1;
  localparam int LOAD_M1 = LOAD_CYCLES - 1;

  logic       sclk_r;
  logic       sclk_nxt;
  logic [4:0] rise_cnt_r;
  logic [4:0] rise_cnt_nxt;

  // Rises since the last strobe; a frame that loses or adds a bit shows here
  always_comb
  begin
    sclk_nxt     = serial_clk;
    rise_cnt_nxt = rise_cnt_r;
    if (!aresetn || load_strobe)
      rise_cnt_nxt = 5'h00;
    else if (serial_clk && !sclk_r)
      rise_cnt_nxt = rise_cnt_r + 5'h01;
    if (!aresetn)
      sclk_nxt = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    sclk_r     <= sclk_nxt;
    rise_cnt_r <= rise_cnt_nxt;
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_strobe_sclk_low: assert property (load_strobe |-> !serial_clk)
    else $error("serial clock high during load strobe");
  a_data_at_rise: assert property ($rose(serial_clk) |-> $stable(serial_data))
    else $error("serial data moved at clock rise");
  a_sclk_high_half: assert property ($rose(serial_clk) |-> ##HALF_M1 serial_clk ##1 !serial_clk)
    else $error("serial clock high phase wrong length");
  a_sclk_low_half: assert property (($fell(serial_clk) && rise_cnt_r < 5'h11)
    |-> ##HALF_M1 !serial_clk ##1 serial_clk)
    else $error("serial clock low phase wrong length");
  a_strobe_bit_count: assert property ($rose(load_strobe) |-> rise_cnt_r == 5'h11)
    else $error("strobe not after exactly seventeen bits");
  a_rise_bound: assert property (rise_cnt_r <= 5'h11)
    else $error("more than seventeen bits in one frame");
  a_strobe_length: assert property ($rose(load_strobe) |-> ##LOAD_M1 load_strobe ##1 !load_strobe)
    else $error("load strobe wrong length");
  a_reset_idle: assert property ($rose(aresetn) |-> !serial_clk && !load_strobe && ref_ratio_sel == 3'h0)
    else $error("link not idle after reset");
endmodule // pll_link_properties
`default_nettype wire

/* File: tb.sv */
`default_nettype none
module tb
  import pll_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int SCLK_HALF   = 16;
  localparam int LOAD_CYCLES = 64;
  localparam int RATIO [8]   = '{8, 16, 64, 128, 256, 512, 1024, 2048};
  localparam int CN [4]      = '{6, 9, 5, 130};
  localparam int CA [4]      = '{3, 67, 0, 127};

  logic        aclk, aresetn, fin_clk;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, psel;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp;
  logic        modulus_ctl, reference_pulse, compare_pulse;
  int          bad_count, total_checks, rises, n, a, p;
  word_t       cap, w;

  pll_link_if link_bus();

  pll_serial_host #(.SCLK_HALF(SCLK_HALF), .LOAD_CYCLES(LOAD_CYCLES)) u_pll_serial_host (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .prescaler_ratio_select(psel), .link(link_bus));

  pll_divider_device u_pll_divider_device (
    .aclk(aclk), .aresetn(aresetn), .link(link_bus), .fin_clk(fin_clk), .modulus_ctl(modulus_ctl),
    .reference_pulse(reference_pulse), .compare_pulse(compare_pulse));

  pll_link_properties #(.SCLK_HALF(SCLK_HALF), .LOAD_CYCLES(LOAD_CYCLES)) props (
    .aclk(aclk), .aresetn(aresetn), .serial_clk(link_bus.serial_clk), .serial_data(link_bus.serial_data),
    .load_strobe(link_bus.load_strobe), .ref_ratio_sel(link_bus.ref_ratio_sel));

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // Prescaler output, unrelated to aclk
  initial
  begin
    fin_clk = 1'b0;
    forever #8 fin_clk = ~fin_clk;
  end

  // Wire-side capture of every frame
  always @(posedge link_bus.serial_clk)
  begin
    cap = {cap[15:0], link_bus.serial_data};
    rises = rises + 1;
  end

  // Modulus control may only move right at a fin fall
  always @(modulus_ctl)
    if (aresetn === 1'b1 && fin_clk !== 1'b0) chk("modulus edge", 32'h0, 32'h1);

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    if (bad_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic hung(input string what);
    bad_count++;
    $display("unexpected %s expected done seen timeout", what);
    complete_run();
  endtask

  task automatic axi_write(input logic [3:0] ad, input logic [31:0] dt, input logic [1:0] er);
    int k;
    logic ah, wh, bh;
    logic [1:0] r;
    k = 0;
    ah = 1'b0;
    wh = 1'b0;
    bh = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= ad;
    wvalid <= 1'b1;
    wdata <= dt;
    wstrb <= 4'hf;
    bready <= 1'b1;
    while (!bh)
    begin
      @(negedge aclk);
      ah = ah || (awvalid && awready);
      wh = wh || (wvalid && wready);
      bh = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      k++;
      if (k > 100) hung("write");
    end
    bready <= 1'b0;
    chk("bresp", 32'h0 | er, 32'h0 | r);
  endtask

  task automatic axi_read(input logic [3:0] ad, output logic [31:0] dt, output logic [1:0] r);
    int k;
    logic ah, rh;
    k = 0;
    ah = 1'b0;
    rh = 1'b0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= ad;
    rready <= 1'b1;
    while (!rh)
    begin
      @(negedge aclk);
      ah = ah || (arvalid && arready);
      rh = rvalid;
      dt = rdata;
      r = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
      k++;
      if (k > 100) hung("read");
    end
    rready <= 1'b0;
  endtask

  task automatic chk_read(input string what, input logic [3:0] ad, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] dt;
    logic [1:0] r;
    axi_read(ad, dt, r);
    chk(what, exp, dt);
    chk("rresp", 32'h0 | er, 32'h0 | r);
  endtask

  // Busy stays up until the strobe drops, so polling bounds the frame
  task automatic wait_idle();
    logic [1:0] r;
    d = 32'h1;
    for (int k = 0; k < 400 && d[0] !== 1'b0; k++)
      axi_read(4'h8, d, r);
    if (d[0] !== 1'b0) hung("frame");
  endtask

  // Fin cycles between compare pulses and how many of them had modulus low
  task automatic measure_div();
    int k;
    k = 0;
    do
    begin
      @(posedge fin_clk);
      k++;
    end
    while (compare_pulse !== 1'b1 && k < 2000);
    if (compare_pulse !== 1'b1) hung("first compare pulse");
    n = 0;
    a = 0;
    do
    begin
      @(posedge fin_clk);
      n++;
      if (modulus_ctl === 1'b0) a++;
    end
    while (compare_pulse !== 1'b1 && n < 2000);
    if (n >= 2000) hung("compare pulse");
  endtask

  task automatic measure_ref();
    int k;
    k = 0;
    // Sampled away from the launching edge so the pulse is settled
    do
    begin
      @(negedge aclk);
      k++;
    end
    while (reference_pulse !== 1'b1 && k < 5000);
    if (reference_pulse !== 1'b1) hung("first reference pulse");
    p = 0;
    do
    begin
      @(negedge aclk);
      p++;
    end
    while (reference_pulse !== 1'b1 && p < 5000);
    if (p >= 5000) hung("reference pulse");
  endtask

  initial
  begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wstrb} = 12'h000;
    wdata = 32'h0;
    {bad_count, total_checks, rises} = {32'h0, 32'h0, 32'h0};
    cap = 17'h00000;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    chk_read("word", 4'h0, 32'h280, 2'h0);
    chk_read("ctrl", 4'h4, 32'h0, 2'h0);
    chk_read("status", 4'h8, 32'h0, 2'h0);
    chk_read("unmapped read", 4'hc, 32'h0, 2'h2);
    axi_write(4'hc, 32'h1, 2'h2);
    // A programmable count of four must never reach the wire
    axi_write(4'h0, 32'h205, 2'h0);
    axi_write(4'h4, 32'h1, 2'h0);
    chk_read("refused", 4'h8, 32'h2, 2'h0);
    axi_write(4'h8, 32'h2, 2'h0);
    chk_read("refused clear", 4'h8, 32'h0, 2'h0);
    chk("bits sent", 32'h0, 32'(rises));
    for (int i = 0; i < 4; i++)
    begin
      w = 17'(CN[i] * 128 + CA[i]);
      axi_write(4'h0, 32'(w), 2'h0);
      rises = 0;
      axi_write(4'h4, (i == 1) ? 32'h3 : 32'h1, 2'h0);
      chk("prescaler select", (i == 1) ? 32'h1 : 32'h0, 32'h0 | psel);
      wait_idle();
      chk("bit count", 32'd17, 32'(rises));
      chk("frame", (i == 1) ? 32'(w & 17'h1ffbf) : 32'(w), 32'(cap));
      chk_read("word kept", 4'h0, 32'(w), 2'h0);
      repeat (3) measure_div();
      chk("n count", 32'(CN[i]), 32'(n));
      chk("a count", 32'((i == 1) ? 3 : CA[i]), 32'(a));
    end
    // New word without a strobe leaves the ratios alone
    axi_write(4'h0, 32'h305, 2'h0);
    repeat (2) measure_div();
    chk("n held", 32'd130, 32'(n));
    chk("a held", 32'd127, 32'(a));
    for (int s = 0; s < 8; s++)
    begin
      axi_write(4'h4, 32'(s * 4), 2'h0);
      repeat (2) measure_ref();
      chk("reference ratio", 32'(RATIO[s]), 32'(p));
    end
    complete_run();
  end
endmodule // tb
`default_nettype wire
